// File: pulse_cmd_pkg.sv
// constants shared by the pulse command decoder and its input front end
`default_nettype none

package pulse_cmd_pkg;

    //////////////////////////////////////////////////////////////////////////
    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    //////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] REG_CTRL         = 8'h00;
    localparam logic [7:0] REG_RATIO_COUNTS = 8'h04;
    localparam logic [7:0] REG_RATIO_REVS   = 8'h08;
    localparam logic [7:0] REG_STATUS       = 8'h0c;
    localparam logic [7:0] REG_IN_COUNT     = 8'h10;
    localparam logic [7:0] REG_POS_CMD      = 8'h14;

    //////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_ENABLE_BIT    = 0;  // pulse mode active
    localparam int CTRL_INTERP_LSB    = 1;  // two-bit interpretation field
    localparam int CTRL_SIGNAL_SE_BIT = 3;  // 1 = single-ended inputs
    localparam int CTRL_POLARITY_BIT  = 4;  // 1 = invert final direction
    localparam int CTRL_USED_W        = 5;  // implemented control bits
    localparam int STATUS_FAULT_BIT   = 0;  // live overspeed condition
    localparam int STATUS_STICKY_BIT  = 1;  // latched overspeed, write 1 clears
    localparam int RATIO_REVS_W       = 16; // width of the revolutions field

    //////////////////////////////////////////////////////////////////////////
    // reset values and limits
    localparam logic [4:0]  CTRL_RESET          = 5'h00;
    localparam logic [31:0] RATIO_COUNTS_RESET  = 32'h0000_2000; // 8192 counts
    localparam logic [15:0] RATIO_REVS_RESET    = 16'h0001;      // per 1 rev
    localparam logic [15:0] MIN_COUNTS_PER_REV  = 16'h000a;      // 10 counts
    localparam logic [15:0] MOTOR_RES_DEFAULT   = 16'h2000;      // motor counts/rev

    //////////////////////////////////////////////////////////////////////////
    // how the two channels are read
    typedef enum logic [1:0] {
        INTERP_UP_DOWN   = 2'b00,
        INTERP_PULSE_DIR = 2'b01,
        INTERP_QUAD      = 2'b10
    } interp_e;

endpackage

`default_nettype wire

// File: pulse_input_frontend.sv
// input front end: pin synchronisers, source select and channel decode
`default_nettype none
`timescale 1ns/1ps

module pulse_input_frontend (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // channel pins, differential receivers and single-ended lines
    input  wire logic       diff_a,
    input  wire logic       diff_b,
    input  wire logic       se_a,
    input  wire logic       se_b,
    // configuration
    input  wire logic       sel_se,
    input  wire logic [1:0] interp,
    // decoded count events, one cycle each
    output logic            count_up,
    output logic            count_dn
);

    logic [3:0] sync_1;       // first stage, read only by stage two
    logic [3:0] sync_2;       // settled pin levels
    logic [3:0] pins;         // raw pins in one vector
    logic       chan_a;       // selected channel a
    logic       chan_b;       // selected channel b
    logic       prev_a;       // channel a one cycle ago
    logic       prev_b;       // channel b one cycle ago

    assign pins = {se_b, se_a, diff_b, diff_a};

    //////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser for each pin
    // synchronise both channels
    // one process for all four bits keeps a single driver per vector
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync_1 <= 4'h0;
            sync_2 <= 4'h0;
        end else begin
            sync_1 <= pins;
            sync_2 <= sync_1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // source select after synchronising, so a switch never makes metastability
    // differential or single-ended
    always_comb begin
        chan_a = sel_se ? sync_2[2] : sync_2[0];
        chan_b = sel_se ? sync_2[3] : sync_2[1];
    end

    // history of the selected channels
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end else begin
            prev_a <= chan_a;
            prev_b <= chan_b;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // edge decode per interpretation
    always_comb begin
        count_up = 1'b0;
        count_dn = 1'b0;
        unique case (interp)
            pulse_cmd_pkg::INTERP_UP_DOWN: begin
                count_up = chan_a & ~prev_a;
                count_dn = chan_b & ~prev_b;
            end
            pulse_cmd_pkg::INTERP_PULSE_DIR: begin
                count_up = chan_a & ~prev_a & chan_b;
                count_dn = chan_a & ~prev_a & ~chan_b;
            end
            pulse_cmd_pkg::INTERP_QUAD: begin
                // a double change is an illegal jump and counts nothing
                if ((chan_a ^ prev_a) ^ (chan_b ^ prev_b)) begin
                    count_up = (prev_a != chan_b);
                    count_dn = (prev_a == chan_b);
                end
            end
            // unused code 2'b11 counts nothing
            default: begin
                count_up = 1'b0;
                count_dn = 1'b0;
            end
        endcase
    end

endmodule // pulse_input_frontend

`default_nettype wire

// File: pulse_command_decoder.sv
// pulse command decoder: pulse stream to scaled motor position command
//
// Behaviour
// - pulse stream drives position and velocity
// - up/down: channel a pulse adds one
// - up/down: channel b pulse subtracts one
// - pulse/direction: b level signs a pulses
// - quadrature: b leading counts positive
// - quadrature counts all edges, four per line
// - signal type picks differential or single-ended
// - single-ended lines carry both channels
// - ratio scales counts into motor position
// - reset ratio: 8192 counts per revolution
// - under 10 counts per rev: overspeed
// - ratio sign and polarity set direction
`default_nettype none
`timescale 1ns/1ps

module pulse_command_decoder #(
    // motor position counts per revolution
    parameter logic [15:0] MOTOR_RES = pulse_cmd_pkg::MOTOR_RES_DEFAULT
) (
    // clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst_b,
    // channel pins
    input  wire logic                              diff_a,
    input  wire logic                              diff_b,
    input  wire logic                              se_a,
    input  wire logic                              se_b,
    // register port
    input  wire logic [pulse_cmd_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [pulse_cmd_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [pulse_cmd_pkg::DATA_W-1:0]  reg_rdata,
    // motion command outputs
    output logic      [31:0]                       pos_cmd,
    output logic      [31:0]                       pos_step,
    output logic                                   overspeed_fault
);

    //////////////////////////////////////////////////////////////////////////
    // declarations
    logic [4:0]  ctrl;             // control register
    logic [4:0]  next_ctrl;
    logic [31:0] ratio_counts;     // signed command counts
    logic [31:0] next_ratio_counts;
    logic [15:0] ratio_revs;       // motor revolutions
    logic [15:0] next_ratio_revs;
    logic        fault_sticky;     // latched overspeed
    logic        next_fault_sticky;
    logic [31:0] reg_rdata_q;      // read data register
    logic [31:0] next_reg_rdata;

    logic [31:0] in_count;         // raw signed input count
    logic [31:0] next_in_count;
    logic [31:0] pos_acc;          // motor position command
    logic [31:0] next_pos_acc;
    logic [31:0] rem;              // scaling remainder, 0..den-1
    logic [31:0] next_rem;
    logic [31:0] step_q;           // delta of the current cycle
    logic [31:0] next_step;
    logic        fault_q;          // registered live fault
    logic        next_fault;

    logic        count_up;         // decoded up event
    logic        count_dn;         // decoded down event
    logic        enable;           // pulse mode active
    logic        polarity;         // final direction invert
    logic        counts_neg;       // ratio sign
    logic [31:0] den;              // ratio count magnitude
    logic [31:0] num;              // motor counts per ratio
    logic [31:0] min_counts;       // least allowed count magnitude
    logic [31:0] quo;              // whole motor counts per input count
    logic [31:0] frac;             // leftover per input count
    logic        fault_now;        // ratio too coarse right now
    logic        wr_ratio;         // a ratio register is written

    //////////////////////////////////////////////////////////////////////////
    // field decode for the write process and the position path
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
        is_addr = (a == off);
    endfunction

    assign enable   = ctrl[pulse_cmd_pkg::CTRL_ENABLE_BIT];
    assign polarity = ctrl[pulse_cmd_pkg::CTRL_POLARITY_BIT];

    //////////////////////////////////////////////////////////////////////////
    // input front end: synchronisers, source select, decode
    // signal type steers source
    pulse_input_frontend u_frontend (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .diff_a   (diff_a),
        .diff_b   (diff_b),
        .se_a     (se_a),
        .se_b     (se_b),
        .sel_se   (ctrl[pulse_cmd_pkg::CTRL_SIGNAL_SE_BIT]),
        .interp   (ctrl[pulse_cmd_pkg::CTRL_INTERP_LSB +: 2]),
        .count_up (count_up),
        .count_dn (count_dn)
    );

    //////////////////////////////////////////////////////////////////////////
    // ratio arithmetic
    // the divider is combinational; it only changes when software writes a
    // ratio, so a multicycle constraint on it is safe in practice
    always_comb begin
        counts_neg = ratio_counts[31];
        den        = counts_neg ? (32'h0000_0000 - ratio_counts) : ratio_counts;
        num        = {16'h0000, ratio_revs} * {16'h0000, MOTOR_RES};
        min_counts = {16'h0000, ratio_revs} * {16'h0000, pulse_cmd_pkg::MIN_COUNTS_PER_REV};
        fault_now  = (ratio_revs == 16'h0000) || (den < min_counts);
        // guarded so a zero divisor never reaches the divider
        if (fault_now || den == 32'h0000_0000) begin
            quo  = 32'h0000_0000;
            frac = 32'h0000_0000;
        end else begin
            quo  = num / den;
            frac = num % den;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // position path next state
    always_comb begin
        logic        dir_neg;
        logic        step_ok;
        logic [32:0] sum;
        logic [31:0] mag;
        dir_neg       = 1'b0;
        step_ok       = 1'b0;
        sum           = 33'h0_0000_0000;
        mag           = 32'h0000_0000;
        next_in_count = in_count;
        next_pos_acc  = pos_acc;
        next_rem      = rem;
        next_step     = 32'h0000_0000;
        next_fault    = fault_now;
        // pulses drive the command
        // simultaneous up and down cancel to no motion
        step_ok = enable && (count_up ^ count_dn);
        if (step_ok) begin
            // raw count keeps the interpretation sign only
            next_in_count = count_up ? in_count + 32'h0000_0001 : in_count - 32'h0000_0001;
        end
        dir_neg = count_dn ^ counts_neg ^ polarity;
        if (step_ok && !fault_now) begin
            if (!dir_neg) begin
                sum = {1'b0, rem} + {1'b0, frac};
                if (sum >= {1'b0, den}) begin
                    next_rem = 32'(sum - {1'b0, den});
                    mag      = quo + 32'h0000_0001;
                end else begin
                    next_rem = sum[31:0];
                    mag      = quo;
                end
                next_step = mag;
            end else begin
                if (rem >= frac) begin
                    next_rem = rem - frac;
                    mag      = quo;
                end else begin
                    next_rem = rem + den - frac;
                    mag      = quo + 32'h0000_0001;
                end
                next_step = 32'h0000_0000 - mag;
            end
            next_pos_acc = pos_acc + next_step;
        end
        // a new ratio restarts the fraction so it stays below the divisor
        if (wr_ratio) begin
            next_rem = 32'h0000_0000;
        end
    end

    // position path registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            in_count <= 32'h0000_0000;
            pos_acc  <= 32'h0000_0000;
            rem      <= 32'h0000_0000;
            step_q   <= 32'h0000_0000;
            fault_q  <= 1'b0;
        end else begin
            in_count <= next_in_count;
            pos_acc  <= next_pos_acc;
            rem      <= next_rem;
            step_q   <= next_step;
            fault_q  <= next_fault;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // register writes next state
    always_comb begin
        next_ctrl         = ctrl;
        next_ratio_counts = ratio_counts;
        next_ratio_revs   = ratio_revs;
        wr_ratio          = 1'b0;
        // set wins over a clear in the same cycle
        next_fault_sticky = fault_sticky | fault_now;
        if (reg_wr) begin
            if (is_addr(reg_addr, pulse_cmd_pkg::REG_CTRL)) begin
                next_ctrl = reg_wdata[pulse_cmd_pkg::CTRL_USED_W-1:0];
            end
            if (is_addr(reg_addr, pulse_cmd_pkg::REG_RATIO_COUNTS)) begin
                next_ratio_counts = reg_wdata;
                wr_ratio          = 1'b1;
            end
            if (is_addr(reg_addr, pulse_cmd_pkg::REG_RATIO_REVS)) begin
                next_ratio_revs = reg_wdata[pulse_cmd_pkg::RATIO_REVS_W-1:0];
                wr_ratio        = 1'b1;
            end
            // write one clears the latched fault unless it is still present
            if (is_addr(reg_addr, pulse_cmd_pkg::REG_STATUS) &&
                reg_wdata[pulse_cmd_pkg::STATUS_STICKY_BIT]) begin
                next_fault_sticky = fault_now;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read data next state; unmapped offsets read zero
    always_comb begin
        next_reg_rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                pulse_cmd_pkg::REG_CTRL: begin
                    next_reg_rdata = {27'h000_0000, ctrl};
                end
                pulse_cmd_pkg::REG_RATIO_COUNTS: begin
                    next_reg_rdata = ratio_counts;
                end
                pulse_cmd_pkg::REG_RATIO_REVS: begin
                    next_reg_rdata = {16'h0000, ratio_revs};
                end
                pulse_cmd_pkg::REG_STATUS: begin
                    next_reg_rdata = {30'h0000_0000, fault_sticky, fault_q};
                end
                pulse_cmd_pkg::REG_IN_COUNT: begin
                    next_reg_rdata = in_count;
                end
                pulse_cmd_pkg::REG_POS_CMD: begin
                    next_reg_rdata = pos_acc;
                end
                default: begin
                    next_reg_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // register file flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl         <= pulse_cmd_pkg::CTRL_RESET;
            ratio_counts <= pulse_cmd_pkg::RATIO_COUNTS_RESET;
            ratio_revs   <= pulse_cmd_pkg::RATIO_REVS_RESET;
            fault_sticky <= 1'b0;
            reg_rdata_q  <= 32'h0000_0000;
        end else begin
            ctrl         <= next_ctrl;
            ratio_counts <= next_ratio_counts;
            ratio_revs   <= next_ratio_revs;
            fault_sticky <= next_fault_sticky;
            reg_rdata_q  <= next_reg_rdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign reg_rdata       = reg_rdata_q;
    assign pos_cmd         = pos_acc;
    assign pos_step        = step_q;
    assign overspeed_fault = fault_q;

endmodule // pulse_command_decoder

`default_nettype wire

// File: pulse_cmd_props.sv
// port checker for the pulse command decoder
`timescale 1ns/1ps
`default_nettype none

module pulse_cmd_props (
    // clock and reset
    input wire logic                             clk_sys,
    input wire logic                             rst_b,
    // channel pins
    input wire logic                             diff_a,
    input wire logic                             diff_b,
    input wire logic                             se_a,
    input wire logic                             se_b,
    // register port
    input wire logic [pulse_cmd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pulse_cmd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                             reg_wr,
    input wire logic                             reg_rd,
    input wire logic [pulse_cmd_pkg::DATA_W-1:0] reg_rdata,
    // motion outputs
    input wire logic [31:0]                      pos_cmd,
    input wire logic [31:0]                      pos_step,
    input wire logic                             overspeed_fault
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    // position only moves by the reported step
    step_sum_a: assert property (pos_cmd == $past(pos_cmd) + pos_step)
        else $error("position moved without matching step");
    // a standing fault gives no motion
    fault_still_a: assert property (overspeed_fault && $past(overspeed_fault) |-> pos_step == 0)
        else $error("motion while overspeed");
    // quiet pins and no writes mean no step; catches duplicated counts
    pins_quiet_a: assert property (($stable({diff_a, diff_b, se_a, se_b}) && !reg_wr)[*6] |-> pos_step == 0)
        else $error("step without pin activity");
    // position register mirrors the output while it holds
    pos_read_a: assert property ((reg_rd && reg_addr == pulse_cmd_pkg::REG_POS_CMD) ##1 (pos_step == 0)
        |-> reg_rdata == pos_cmd) else $error("position read mismatch");
    // control readback right after a write
    ctrl_back_a: assert property ((reg_wr && reg_addr == pulse_cmd_pkg::REG_CTRL) ##1
        (reg_rd && reg_addr == pulse_cmd_pkg::REG_CTRL) |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 2))
        else $error("control readback mismatch");
    // live and latched fault both seen in status
    status_live_a: assert property ((overspeed_fault && reg_rd && reg_addr == pulse_cmd_pkg::REG_STATUS)
        ##1 overspeed_fault |-> reg_rdata[1:0] == 2'b11) else $error("status misses fault");
    // unmapped place reads as zero
    unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 0)
        else $error("unmapped read not zero");
    // read data only in the cycle after a read
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 0)
        else $error("read data outside read answer");

    ////////////////////////////////////////////////////////////////////////
    // main scenarios reached
    fault_c: cover property ($rose(overspeed_fault));
    back_c: cover property (pos_step[31]);
    fwd_c: cover property (pos_step == 32'h2);
endmodule // pulse_cmd_props

`default_nettype wire

// File: pulse_source_model.sv
// pulse source standing in for the external motion controller
`timescale 1ns/1ps
`default_nettype none

module pulse_source_model (
    // clock
    input wire logic  clk_sys,
    // which pair carries the command
    input wire logic  sel_se,
    // channel pins
    output logic      diff_a,
    output logic      diff_b,
    output logic      se_a,
    output logic      se_b
);
    logic a = 1'b0; // command channel a level
    logic b = 1'b0; // command channel b level

    // selected pair commands
    // the other pair carries a swapped copy, so a wrong pick miscounts
    assign diff_a = sel_se ? b : a;
    assign diff_b = sel_se ? a : b;
    assign se_a   = sel_se ? a : b;
    assign se_b   = sel_se ? b : a;

    // direction level held
    // levels stand for hold cycles; 2 is the fastest legal rate
    task automatic set_ab(input logic na, input logic nb, input int hold);
        a <= na;
        b <= nb;
        repeat (hold) @(posedge clk_sys);
    endtask
endmodule // pulse_source_model

`default_nettype wire

// File: testbench.sv
// self-checking bench for the pulse command decoder
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // one table row: setup, stimulus, expected deltas
    typedef struct {
        logic [4:0]  ctrl;
        logic [31:0] cnt;
        logic [15:0] revs;
        logic [1:0]  kind;
        logic        d;
        int          n;
        logic [31:0] exp_in;
        logic [31:0] exp_pos;
        logic        flt;
    } row_s;

    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        src_sel = 1'b0;
    logic        diff_a, diff_b, se_a, se_b;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, pos_cmd, pos_step, v0, v1, p0;
    logic        overspeed_fault;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    row_s        rows [19];

    pulse_source_model pulse_source_model_i (.clk_sys(clk_sys), .sel_se(src_sel), .diff_a(diff_a),
        .diff_b(diff_b), .se_a(se_a), .se_b(se_b));
    pulse_command_decoder pulse_command_decoder_i (.clk_sys(clk_sys), .rst_b(rst_b), .diff_a(diff_a),
        .diff_b(diff_b), .se_a(se_a), .se_b(se_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_cmd(pos_cmd),
        .pos_step(pos_step), .overspeed_fault(overspeed_fault));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            num_errors++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // write strobe stays up for back-to-back writes; others drop it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic reset_values();
        logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
        logic [31:0] rv [6] = '{32'h0, 32'h2000, 32'h1, 32'h0, 32'h0, 32'h0};
        check("pos_cmd", pos_cmd, 32'h0);
        check("fault", {31'h0, overspeed_fault}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], v0);
            check("reset reg", v0, rv[i]);
        end
    endtask
    // quad steps given as {a,b}; pulse kinds rise and fall once per n
    task automatic pattern(input logic [1:0] k, input logic d, input int n);
        logic [1:0] q [2][4] = '{'{2'b01, 2'b11, 2'b10, 2'b00}, '{2'b10, 2'b11, 2'b01, 2'b00}};
        repeat (n) begin
            if (k[1]) begin
                for (int j = 0; j < 4; j++) pulse_source_model_i.set_ab(q[k[0]][j][1], q[k[0]][j][0], 2);
            end else begin
                pulse_source_model_i.set_ab(!k[0], k[0] | d, 5);
                pulse_source_model_i.set_ab(1'b0, d, 5);
            end
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rows = '{
            '{5'h01, 32'h2000, 16'h1, 2'd0, 1'b0, 3, 32'h3, 32'h3, 1'b0},
            '{5'h01, 32'h2000, 16'h1, 2'd1, 1'b0, 2, 32'hffff_fffe, 32'hffff_fffe, 1'b0},
            '{5'h03, 32'h2000, 16'h1, 2'd0, 1'b1, 2, 32'h2, 32'h2, 1'b0},
            '{5'h03, 32'h2000, 16'h1, 2'd0, 1'b0, 2, 32'hffff_fffe, 32'hffff_fffe, 1'b0},
            '{5'h05, 32'h2000, 16'h1, 2'd2, 1'b0, 1, 32'h4, 32'h4, 1'b0},
            '{5'h05, 32'h2000, 16'h1, 2'd3, 1'b0, 2, 32'hffff_fff8, 32'hffff_fff8, 1'b0},
            '{5'h09, 32'h2000, 16'h1, 2'd0, 1'b0, 3, 32'h3, 32'h3, 1'b0},
            '{5'h0b, 32'h2000, 16'h1, 2'd0, 1'b1, 1, 32'h1, 32'h1, 1'b0},
            '{5'h0d, 32'h2000, 16'h1, 2'd3, 1'b0, 1, 32'hffff_fffc, 32'hffff_fffc, 1'b0},
            '{5'h11, 32'h2000, 16'h1, 2'd0, 1'b0, 2, 32'h2, 32'hffff_fffe, 1'b0},
            '{5'h01, 32'hffff_e000, 16'h1, 2'd0, 1'b0, 2, 32'h2, 32'hffff_fffe, 1'b0},
            '{5'h11, 32'hffff_e000, 16'h1, 2'd0, 1'b0, 2, 32'h2, 32'h2, 1'b0},
            '{5'h01, 32'h1000, 16'h1, 2'd0, 1'b0, 3, 32'h3, 32'h6, 1'b0},
            '{5'h01, 32'h6000, 16'h1, 2'd0, 1'b0, 3, 32'h3, 32'h1, 1'b0},
            '{5'h01, 32'h2000, 16'h2, 2'd0, 1'b0, 2, 32'h2, 32'h4, 1'b0},
            '{5'h01, 32'ha, 16'h1, 2'd0, 1'b0, 1, 32'h1, 32'h333, 1'b0},
            '{5'h00, 32'h2000, 16'h1, 2'd0, 1'b0, 2, 32'h0, 32'h0, 1'b0},
            '{5'h07, 32'h2000, 16'h1, 2'd0, 1'b0, 2, 32'h0, 32'h0, 1'b0},
            '{5'h01, 32'h9, 16'h1, 2'd0, 1'b0, 2, 32'h2, 32'h0, 1'b1}};
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        reset_values();
        // table rows: source switch and levels settle while counting is off
        foreach (rows[i]) begin
            wr(8'h00, 32'h0);
            reg_wr <= 1'b0;
            src_sel <= rows[i].ctrl[3];
            pulse_source_model_i.set_ab(1'b0, rows[i].d, 5);
            wr(8'h04, rows[i].cnt);
            wr(8'h08, {16'h0, rows[i].revs});
            wr(8'h00, {27'h0, rows[i].ctrl});
            rd(8'h10, v0);
            rd(8'h14, p0);
            pattern(rows[i].kind, rows[i].d, rows[i].n);
            repeat (6) @(posedge clk_sys);
            rd(8'h10, v1);
            check("in_count", v1 - v0, rows[i].exp_in);
            rd(8'h14, v1);
            check("pos_cmd", v1 - p0, rows[i].exp_pos);
            check("fault", {31'h0, overspeed_fault}, {31'h0, rows[i].flt});
        end
        // latched fault outlives the coarse ratio until cleared
        rd(8'h0c, v0);
        check("status", v0, 32'h3);
        wr(8'h04, 32'h2000);
        reg_wr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd(8'h0c, v0);
        check("status sticky", v0, 32'h2);
        wr(8'h0c, 32'h2);
        rd(8'h0c, v0);
        check("status cleared", v0, 32'h0);
        // unmapped place and back-to-back control access
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, v0);
        check("unmapped", v0, 32'h0);
        wr(8'h00, 32'h13);
        rd(8'h00, v0);
        check("ctrl", v0, 32'h13);
        // second reset in mid-run
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        reset_values();
        finish_test();
    end
endmodule // testbench

bind pulse_command_decoder pulse_cmd_props pulse_cmd_props_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .diff_a(diff_a), .diff_b(diff_b), .se_a(se_a), .se_b(se_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pos_cmd(pos_cmd), .pos_step(pos_step), .overspeed_fault(overspeed_fault));

`default_nettype wire
